// ===== preamp_digital_control_link.sv
/*
 * digital logic of the preamplifier side of the control link: fast reset
 * control and inhibit lines, pulser attenuation, shape and trigger, fine
 * gain receiver, and an Avalon-MM slave for monitoring and interrupts.
 * assumes all link pins are asynchronous to CORE_CLK_IN (100 MHz).
 */
`timescale 1ns/1ps
module preamp_digital_control_link
    import preamp_link_pkg::*;
(
    // clock and reset
    input  wire logic                                CORE_CLK_IN,
    input  wire logic                                RST_B_IN,
    // saturation demand from each preamplifier
    input  wire logic [preamp_link_pkg::CHAN_NUM-1:0] SATURATED_IN,
    // fast reset shutdown lines
    input  wire logic                                FAST_RESET_OFF_TRIPLE_A_IN,
    input  wire logic                                FAST_RESET_OFF_TRIPLE_B_IN,
    input  wire logic                                FAST_RESET_OFF_CORE_ONE_IN,
    input  wire logic                                FAST_RESET_OFF_CORE_TWO_IN,
    // pulser control lines
    input  wire logic                                PULSER_ATTEN_LINE_1_IN,
    input  wire logic                                PULSER_ATTEN_LINE_2_IN,
    input  wire logic                                PULSER_ATTEN_LINE_3_IN,
    input  wire logic                                PULSER_ATTEN_LINE_4_IN,
    input  wire logic                                PULSER_SHAPE_SELECT_IN,
    input  wire logic                                PULSER_TRIGGER_IN,
    // fine gain serial link
    input  wire logic                                GAIN_SCLK_IN,
    input  wire logic                                GAIN_DIN_IN,
    input  wire logic                                GAIN_CS_N_IN,
    // unused supply enable
    input  wire logic                                POWER_SUPPLY_ENABLE_IN,
    // fast reset and inhibit outputs
    output logic [preamp_link_pkg::CHAN_NUM-1:0]     FAST_RESET_FIRE_OUT,
    output logic                                     RESET_INHIBIT_TRIPLE_A_OUT,
    output logic                                     RESET_INHIBIT_TRIPLE_B_OUT,
    output logic                                     RESET_INHIBIT_CORE_ONE_OUT,
    output logic                                     RESET_INHIBIT_CORE_TWO_OUT,
    // pulser and fine gain outputs
    output logic [preamp_link_pkg::ATTEN_DB_W-1:0]   PULSER_ATTEN_DB_OUT,
    output logic                                     PULSER_SHAPE_EXP_OUT,
    output logic                                     PULSER_STEP_UP_OUT,
    output logic                                     PULSER_STEP_DOWN_OUT,
    output logic [preamp_link_pkg::GAIN_BITS-1:0]    FINE_GAIN_OUT,
    // avalon-mm slave
    input  wire logic [preamp_link_pkg::ADDR_W-1:0]  AVS_ADDRESS_IN,
    input  wire logic                                AVS_READ_IN,
    input  wire logic                                AVS_WRITE_IN,
    input  wire logic [31:0]                         AVS_WRITEDATA_IN,
    input  wire logic [3:0]                          AVS_BYTEENABLE_IN,
    output logic [31:0]                              AVS_READDATA_OUT,
    output logic                                     AVS_WAITREQUEST_OUT,
    // interrupt
    output logic                                     IRQ_OUT
);
    import preamp_link_pkg::*;

    // ==========================================================
    // pin synchronisers
    logic [PIN_W-1:0] pin_bus;
    logic [PIN_W-1:0] sync1_ff;
    logic [PIN_W-1:0] sync2_ff;

    // the supply enable pin is deliberately left out of the bundle
    assign pin_bus = {GAIN_CS_N_IN, GAIN_DIN_IN, GAIN_SCLK_IN, PULSER_TRIGGER_IN, PULSER_SHAPE_SELECT_IN,
                      PULSER_ATTEN_LINE_4_IN, PULSER_ATTEN_LINE_3_IN, PULSER_ATTEN_LINE_2_IN,
                      PULSER_ATTEN_LINE_1_IN, FAST_RESET_OFF_CORE_TWO_IN, FAST_RESET_OFF_CORE_ONE_IN,
                      FAST_RESET_OFF_TRIPLE_B_IN, FAST_RESET_OFF_TRIPLE_A_IN, SATURATED_IN};

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            sync1_ff <= {1'b1, {(PIN_W-1){1'b0}}};
            sync2_ff <= {1'b1, {(PIN_W-1){1'b0}}};
        end else begin
            sync1_ff <= pin_bus;
            sync2_ff <= sync1_ff;
        end
    end

    logic [CHAN_NUM-1:0]  sat_s;
    logic [GROUP_NUM-1:0] off_s;
    logic [ATTEN_NUM-1:0] atten_s;

    assign sat_s   = sync2_ff[POS_SAT +: CHAN_NUM];
    assign off_s   = sync2_ff[POS_OFF +: GROUP_NUM];
    assign atten_s = sync2_ff[POS_ATTEN +: ATTEN_NUM];

    // ==========================================================
    // fast reset and inhibit per group
    logic [CHAN_NUM-1:0]  fire_ff,    nxt_fire;
    logic [GROUP_NUM-1:0] inhibit_ff, nxt_inhibit;

    function automatic int group_of(input int ch);
        if (ch < 3) begin
            return 0;
        end else if (ch < 6) begin
            return 1;
        end else if (ch == 6) begin
            return 2;
        end else begin
            return 3;
        end
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < CHAN_NUM; gi++) begin : g_chan
            // fire while saturated unless the group is shut down
            assign nxt_fire[gi] = sat_s[gi] && !off_s[group_of(gi)];
        end
        for (gi = 0; gi < GROUP_NUM; gi++) begin : g_group
            logic [CHAN_NUM-1:0] member;
            for (genvar ci = 0; ci < CHAN_NUM; ci++) begin : g_member
                assign member[ci] = (group_of(ci) == gi);
            end
            assign nxt_inhibit[gi] = |(nxt_fire & member);
        end
    endgenerate

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            fire_ff    <= '0;
            inhibit_ff <= '0;
        end else begin
            fire_ff    <= nxt_fire;
            inhibit_ff <= nxt_inhibit;
        end
    end

    assign FAST_RESET_FIRE_OUT        = fire_ff;
    assign RESET_INHIBIT_TRIPLE_A_OUT = inhibit_ff[0];
    assign RESET_INHIBIT_TRIPLE_B_OUT = inhibit_ff[1];
    assign RESET_INHIBIT_CORE_ONE_OUT = inhibit_ff[2];
    assign RESET_INHIBIT_CORE_TWO_OUT = inhibit_ff[3];

    // ==========================================================
    // pulser attenuation, shape and trigger
    logic [CTRL_W-1:0]     ctrl_ff, nxt_ctrl;
    logic [ATTEN_DB_W-1:0] atten_db_ff, nxt_atten_db;
    logic                  shape_ff, nxt_shape;
    logic                  trig_d_ff, nxt_trig_d;
    logic                  up_ff, nxt_up;
    logic                  down_ff, nxt_down;

    always_comb begin
        nxt_atten_db = '0;
        for (int i = 0; i < ATTEN_NUM; i++) begin
            if (atten_s[i]) begin
                nxt_atten_db = nxt_atten_db + ATTEN_STEP_DB;
            end
        end
        nxt_shape  = sync2_ff[POS_SHAPE];
        nxt_trig_d = sync2_ff[POS_TRIG];
        nxt_up     = ctrl_ff[CTRL_PULSER_EN] && trig_d_ff && !sync2_ff[POS_TRIG];
        nxt_down   = ctrl_ff[CTRL_PULSER_EN] && !trig_d_ff && sync2_ff[POS_TRIG];
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            atten_db_ff <= '0;
            shape_ff    <= 1'b0;
            trig_d_ff   <= 1'b0;
            up_ff       <= 1'b0;
            down_ff     <= 1'b0;
        end else begin
            atten_db_ff <= nxt_atten_db;
            shape_ff    <= nxt_shape;
            trig_d_ff   <= nxt_trig_d;
            up_ff       <= nxt_up;
            down_ff     <= nxt_down;
        end
    end

    assign PULSER_ATTEN_DB_OUT  = atten_db_ff;
    assign PULSER_SHAPE_EXP_OUT = shape_ff;
    assign PULSER_STEP_UP_OUT   = up_ff;
    assign PULSER_STEP_DOWN_OUT = down_ff;

    // ==========================================================
    // fine gain receiver
    logic [GAIN_BITS-1:0] gain;
    logic                 gain_load;
    logic                 gain_err;

    fine_gain_shift_rx u_gain_rx (
        .clk_in        (CORE_CLK_IN),
        .rst_b_in      (RST_B_IN),
        .sclk_in       (sync2_ff[POS_SCLK]),
        .din_in        (sync2_ff[POS_DIN]),
        .cs_n_in       (sync2_ff[POS_CSN]),
        .load_en_in    (ctrl_ff[CTRL_GAIN_EN]),
        .gain_out      (gain),
        .load_out      (gain_load),
        .frame_err_out (gain_err)
    );

    assign FINE_GAIN_OUT = gain;

    // ==========================================================
    // register slave and interrupts
    logic              ack_ff, nxt_ack;
    logic [31:0]       rdata_ff, nxt_rdata;
    logic [IRQ_W-1:0]  irq_stat_ff, nxt_irq_stat;
    logic [IRQ_W-1:0]  irq_mask_ff, nxt_irq_mask;
    logic [IRQ_W-1:0]  irq_snap_ff, nxt_irq_snap;
    logic              irq_ff, nxt_irq;
    logic              req;
    logic [IRQ_W-1:0]  events;

    assign req    = AVS_READ_IN || AVS_WRITE_IN;
    assign events = {up_ff || down_ff, gain_err, gain_load, |(nxt_fire & ~fire_ff)};

    always_comb begin
        nxt_ack      = req && !ack_ff;
        nxt_rdata    = rdata_ff;
        nxt_ctrl     = ctrl_ff;
        nxt_irq_mask = irq_mask_ff;
        nxt_irq_snap = irq_snap_ff;
        nxt_irq_stat = irq_stat_ff;
        if (AVS_READ_IN && !ack_ff) begin
            nxt_rdata = 32'h0000_0000;
            case (AVS_ADDRESS_IN)
                OFS_CTRL: begin
                    nxt_rdata[CTRL_W-1:0] = ctrl_ff;
                end
                OFS_STATUS: begin
                    nxt_rdata[STAT_INH +: GROUP_NUM]   = inhibit_ff;
                    nxt_rdata[STAT_OFF +: GROUP_NUM]   = off_s;
                    nxt_rdata[STAT_ATTEN +: ATTEN_NUM] = atten_s;
                    nxt_rdata[STAT_SHAPE]              = shape_ff;
                    nxt_rdata[STAT_FIRE +: CHAN_NUM]   = fire_ff;
                end
                OFS_GAIN: begin
                    nxt_rdata[GAIN_BITS-1:0] = gain;
                end
                OFS_IRQ_STAT: begin
                    nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
                end
                OFS_IRQ_MASK: begin
                    nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
                end
                default: begin
                    nxt_rdata = 32'h0000_0000;
                end
            endcase
            nxt_irq_snap = (AVS_ADDRESS_IN == OFS_IRQ_STAT) ? irq_stat_ff : '0;
        end
        // read clears only the bits it returned, new events win
        if (AVS_READ_IN && ack_ff) begin
            nxt_irq_stat = irq_stat_ff & ~irq_snap_ff;
        end
        nxt_irq_stat = nxt_irq_stat | events;
        if (AVS_WRITE_IN && ack_ff && AVS_BYTEENABLE_IN[0]) begin
            if (AVS_ADDRESS_IN == OFS_CTRL) begin
                nxt_ctrl = AVS_WRITEDATA_IN[CTRL_W-1:0];
            end
            if (AVS_ADDRESS_IN == OFS_IRQ_MASK) begin
                nxt_irq_mask = AVS_WRITEDATA_IN[IRQ_W-1:0];
            end
        end
        nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ack_ff      <= 1'b0;
            rdata_ff    <= 32'h0000_0000;
            ctrl_ff     <= CTRL_RESET;
            irq_mask_ff <= IRQ_MASK_RESET;
            irq_snap_ff <= '0;
            irq_stat_ff <= '0;
            irq_ff      <= 1'b0;
        end else begin
            ack_ff      <= nxt_ack;
            rdata_ff    <= nxt_rdata;
            ctrl_ff     <= nxt_ctrl;
            irq_mask_ff <= nxt_irq_mask;
            irq_snap_ff <= nxt_irq_snap;
            irq_stat_ff <= nxt_irq_stat;
            irq_ff      <= nxt_irq;
        end
    end

    assign AVS_READDATA_OUT    = rdata_ff;
    assign AVS_WAITREQUEST_OUT = req && !ack_ff;
    assign IRQ_OUT             = irq_ff;

    // ==========================================================
    // checks
    property p_inhibit_group_a;
        @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
        ##3 RESET_INHIBIT_TRIPLE_A_OUT == |($past(SATURATED_IN[2:0], 3) & {3{!$past(FAST_RESET_OFF_TRIPLE_A_IN, 3)}});
    endproperty
    a_inhibit_group_a: assert property (p_inhibit_group_a)
        else $error("triple a inhibit does not follow its fast resets");

    property p_off_blocks_fire;
        @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
        ##3 $past(FAST_RESET_OFF_TRIPLE_B_IN, 3) |-> FAST_RESET_FIRE_OUT[5:3] == 3'h0;
    endproperty
    a_off_blocks_fire: assert property (p_off_blocks_fire)
        else $error("fast reset fired while its group was shut down");

    property p_fire_when_enabled;
        @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
        ##3 (!$past(FAST_RESET_OFF_CORE_ONE_IN, 3) && $past(SATURATED_IN[6], 3)) |-> FAST_RESET_FIRE_OUT[6];
    endproperty
    a_fire_when_enabled: assert property (p_fire_when_enabled)
        else $error("saturated core one did not fast reset");

    property p_atten_db;
        @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
        ##3 PULSER_ATTEN_DB_OUT == ATTEN_DB_W'(10 * $countones({$past(PULSER_ATTEN_LINE_1_IN, 3),
            $past(PULSER_ATTEN_LINE_2_IN, 3), $past(PULSER_ATTEN_LINE_3_IN, 3), $past(PULSER_ATTEN_LINE_4_IN, 3)}));
    endproperty
    a_atten_db: assert property (p_atten_db)
        else $error("attenuation is not ten decibels per active line");

    property p_shape;
        @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
        ##3 PULSER_SHAPE_EXP_OUT == $past(PULSER_SHAPE_SELECT_IN, 3);
    endproperty
    a_shape: assert property (p_shape)
        else $error("pulser shape does not follow the select line");

    sequence s_trig_fall;
        ##4 $past(PULSER_TRIGGER_IN, 4) && !$past(PULSER_TRIGGER_IN, 3) && $past(ctrl_ff[CTRL_PULSER_EN]);
    endsequence

    property p_step_up;
        @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
        s_trig_fall |-> PULSER_STEP_UP_OUT && !PULSER_STEP_DOWN_OUT;
    endproperty
    a_step_up: assert property (p_step_up)
        else $error("falling trigger edge gave no positive step");

    property p_wait_bounded;
        @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
        $rose(req) |-> AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT;
    endproperty
    a_wait_bounded: assert property (p_wait_bounded)
        else $error("waitrequest not released after one cycle");

    property p_irq_level;
        @(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
        ##1 IRQ_OUT == |(irq_stat_ff & irq_mask_ff);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt output disagrees with masked status");

endmodule

// ===== preamp_link_pkg.sv
/*
 * shared constants of the preamplifier digital control link:
 * pin bundle layout, register map, reset values and field positions.
 * assumes a single 100 MHz core clock and a 32-bit Avalon-MM slave port.
 */
package preamp_link_pkg;

    // ==========================================================
    // channels and groups
    localparam int CHAN_NUM      = 8;
    localparam int GROUP_NUM     = 4;
    localparam int ATTEN_NUM     = 4;
    localparam int GAIN_BITS     = 16;
    localparam int GAIN_CNT_W    = 5;
    localparam int ATTEN_DB_W    = 6;
    localparam logic [ATTEN_DB_W-1:0] ATTEN_STEP_DB = 6'h0a;

    // ==========================================================
    // synchronised pin bundle layout
    localparam int POS_SAT   = 0;
    localparam int POS_OFF   = 8;
    localparam int POS_ATTEN = 12;
    localparam int POS_SHAPE = 16;
    localparam int POS_TRIG  = 17;
    localparam int POS_SCLK  = 18;
    localparam int POS_DIN   = 19;
    localparam int POS_CSN   = 20;
    localparam int PIN_W     = 21;

    // ==========================================================
    // clock and serial link timing
    localparam int CORE_CLK_HZ  = 100_000_000;
    localparam int GAIN_SCLK_HZ = 25_000_000;
    localparam int GAIN_SCLK_MIN_CYC = (CORE_CLK_HZ + GAIN_SCLK_HZ - 1) / GAIN_SCLK_HZ;

    // ==========================================================
    // register map (byte addresses)
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_GAIN     = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h10;

    // ctrl fields
    localparam int CTRL_PULSER_EN = 0;
    localparam int CTRL_GAIN_EN   = 1;
    localparam int CTRL_W         = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h3;

    // status fields
    localparam int STAT_INH   = 0;
    localparam int STAT_OFF   = 4;
    localparam int STAT_ATTEN = 8;
    localparam int STAT_SHAPE = 12;
    localparam int STAT_FIRE  = 16;

    // interrupt fields
    localparam int IRQ_FAST_RESET = 0;
    localparam int IRQ_GAIN_LOAD  = 1;
    localparam int IRQ_FRAME_ERR  = 2;
    localparam int IRQ_PULSER     = 3;
    localparam int IRQ_W          = 4;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

endpackage

// ===== fine_gain_shift_rx.sv
/*
 * three-wire fine-gain receiver: shifts 16 bits msb first on rising
 * serial clock edges while chip select is low, loads on chip select rise after exactly 16 bits when enabled.
 * assumes all three lines are already synchronised to the core clock.
 */
`timescale 1ns/1ps
module fine_gain_shift_rx
    import preamp_link_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_b_in,
    // synchronised link lines and gain load enable
    input  wire logic                 sclk_in,
    input  wire logic                 din_in,
    input  wire logic                 cs_n_in,
    input  wire logic                 load_en_in,
    // results
    output logic [GAIN_BITS-1:0]      gain_out,
    output logic                      load_out,
    output logic                      frame_err_out
);
    import preamp_link_pkg::*;

    logic [GAIN_BITS-1:0]  shift_ff,  nxt_shift;
    logic [GAIN_BITS-1:0]  gain_ff,   nxt_gain;
    logic [GAIN_CNT_W-1:0] count_ff,  nxt_count;
    logic                  sclk_d_ff, csn_d_ff;
    logic                  load_ff,   nxt_load;
    logic                  err_ff,    nxt_err;

    // ==========================================================
    // shift and load
    always_comb begin
        nxt_shift = shift_ff;
        nxt_gain  = gain_ff;
        nxt_count = count_ff;
        nxt_load  = 1'b0;
        nxt_err   = 1'b0;
        if (csn_d_ff && !cs_n_in) begin
            nxt_count = '0;
        end else if (!cs_n_in && sclk_in && !sclk_d_ff) begin
            nxt_shift = {shift_ff[GAIN_BITS-2:0], din_in};
            if (count_ff != GAIN_CNT_W'(GAIN_BITS + 1)) begin
                nxt_count = count_ff + 1'b1;
            end
        end else if (!csn_d_ff && cs_n_in) begin
            if (count_ff == GAIN_CNT_W'(GAIN_BITS) && load_en_in) begin
                nxt_gain = shift_ff;
                nxt_load = 1'b1;
            end else begin
                nxt_err = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            shift_ff  <= '0;
            gain_ff   <= '0;
            count_ff  <= '0;
            sclk_d_ff <= 1'b0;
            csn_d_ff  <= 1'b1;
            load_ff   <= 1'b0;
            err_ff    <= 1'b0;
        end else begin
            shift_ff  <= nxt_shift;
            gain_ff   <= nxt_gain;
            count_ff  <= nxt_count;
            sclk_d_ff <= sclk_in;
            csn_d_ff  <= cs_n_in;
            load_ff   <= nxt_load;
            err_ff    <= nxt_err;
        end
    end

    assign gain_out      = gain_ff;
    assign load_out      = load_ff;
    assign frame_err_out = err_ff;

    // ==========================================================
    // checks
    sequence s_cs_rise_full;
        !csn_d_ff && cs_n_in && count_ff == GAIN_CNT_W'(GAIN_BITS) && load_en_in;
    endsequence

    property p_load_after_sixteen;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_cs_rise_full |=> load_out && gain_out == $past(shift_ff);
    endproperty
    a_load_after_sixteen: assert property (p_load_after_sixteen)
        else $error("gain not loaded after a full sixteen bit frame");

    property p_gain_holds;
        @(posedge clk_in) disable iff (!rst_b_in)
        !load_out |-> $stable(gain_out);
    endproperty
    a_gain_holds: assert property (p_gain_holds)
        else $error("gain changed without a load");

endmodule

// ===== digitiser_link_model.sv
/*
 * digitiser side of the fine-gain serial link: frames words on a
 * 125 ns serial clock that stands still outside frames.
 * assumes the caller waits for the task to return between frames.
 */
`timescale 1ns/1ps
module digitiser_link_model (
    // serial link lines
    output logic sclk_out,
    output logic din_out,
    output logic cs_n_out
);
    // ==========================================================
    // frame driver
    initial begin
        sclk_out = 1'b0;
        din_out  = 1'b0;
        cs_n_out = 1'b1;
    end

    task automatic send(input logic [15:0] w, input int n);
        cs_n_out = 1'b0;
        #100;
        for (int i = 15; i > 15 - n; i--) begin
            din_out = w[i];
            #62.5 sclk_out = 1'b1;
            #62.5 sclk_out = 1'b0;
        end
        #60 cs_n_out = 1'b1;
        din_out = ~din_out;
    endtask
endmodule

// ===== preamp_digital_control_link_bench.sv
/*
 * self-checking bench of the preamplifier control link.
 * assumes the digitiser model drives the serial link.
 */
`timescale 1ns/1ps
module preamp_digital_control_link_bench;
    import preamp_link_pkg::*;
    // ==========================================================
    // signals
    logic clk = 0, rst_b = 0, shp = 0, trg = 1, pse = 0, rd = 0, wr = 0;
    logic sexp, up, dn, wreq, irq, sclk, din, csn;
    logic [7:0] sat = 8'h00, fire;
    logic [3:0] off = 4'h0, att = 4'h0, inh;
    logic [5:0] db;
    logic [15:0] gain;
    logic [4:0] adr = 5'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    int fail_count = 0, num_checks = 0;
    always #5 clk = ~clk;
    digitiser_link_model PRT (.sclk_out(sclk), .din_out(din), .cs_n_out(csn));
    preamp_digital_control_link DUT (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .SATURATED_IN(sat),
        .FAST_RESET_OFF_TRIPLE_A_IN(off[0]), .FAST_RESET_OFF_TRIPLE_B_IN(off[1]),
        .FAST_RESET_OFF_CORE_ONE_IN(off[2]), .FAST_RESET_OFF_CORE_TWO_IN(off[3]),
        .PULSER_ATTEN_LINE_1_IN(att[0]), .PULSER_ATTEN_LINE_2_IN(att[1]), .PULSER_ATTEN_LINE_3_IN(att[2]),
        .PULSER_ATTEN_LINE_4_IN(att[3]), .PULSER_SHAPE_SELECT_IN(shp), .PULSER_TRIGGER_IN(trg),
        .GAIN_SCLK_IN(sclk), .GAIN_DIN_IN(din), .GAIN_CS_N_IN(csn), .POWER_SUPPLY_ENABLE_IN(pse),
        .FAST_RESET_FIRE_OUT(fire), .RESET_INHIBIT_TRIPLE_A_OUT(inh[0]), .RESET_INHIBIT_TRIPLE_B_OUT(inh[1]),
        .RESET_INHIBIT_CORE_ONE_OUT(inh[2]), .RESET_INHIBIT_CORE_TWO_OUT(inh[3]), .PULSER_ATTEN_DB_OUT(db),
        .PULSER_SHAPE_EXP_OUT(sexp), .PULSER_STEP_UP_OUT(up), .PULSER_STEP_DOWN_OUT(dn), .FINE_GAIN_OUT(gain),
        .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
        .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq), .IRQ_OUT(irq));
    // ==========================================================
    // helpers
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        chk("waitrequest", 0, wreq);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic trig(input logic v, input int eu, input int ed);
        int u, d;
        u = 0;
        d = 0;
        @(posedge clk);
        trg <= v;
        repeat (8) begin
            @(negedge clk);
            u += (up === 1'b1);
            d += (dn === 1'b1);
        end
        chk("step_up", eu, u);
        chk("step_down", ed, d);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_fast;
        @(posedge clk);
        sat <= 8'h49;
        repeat (5) @(posedge clk);
        chk("fire", 8'h49, fire);
        chk("inhibit", 4'h7, inh);
        @(posedge clk);
        off <= 4'h7;
        repeat (5) @(posedge clk);
        chk("fire_off", 0, fire);
        chk("inhibit_off", 0, inh);
        @(posedge clk);
        sat <= 8'h00;
        off <= 4'h0;
    endtask
    task automatic t_width;
        int w;
        w = 0;
        @(posedge clk);
        sat <= 8'h01;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            if (i == 9) sat <= 8'h00;
            w += (inh[0] === 1'b1);
        end
        chk("inhibit_width", 10, w);
    endtask
    task automatic t_pulser;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            att <= i[3:0];
            shp <= i[0];
            pse <= i[1];
            repeat (5) @(posedge clk);
            chk("atten_db", $countones(i[3:0]) * 10, db);
            chk("shape", i[0], sexp);
        end
    endtask
    task automatic t_gain;
        bus(0, OFS_IRQ_STAT, 0);
        bus(1, OFS_IRQ_MASK, 32'h2);
        PRT.send(16'hc35a, 16);
        repeat (6) @(posedge clk);
        chk("gain", 16'hc35a, gain);
        chk("irq", 1, irq);
        bus(0, OFS_GAIN, 0);
        chk("gain_reg", 16'hc35a, q);
        bus(0, OFS_IRQ_STAT, 0);
        chk("irq_stat", 2, q[3:0]);
        repeat (3) @(posedge clk);
        chk("irq_clear", 0, irq);
        PRT.send(16'h1234, 15);
        repeat (6) @(posedge clk);
        chk("gain_short", 16'hc35a, gain);
        chk("irq_masked", 0, irq);
        bus(0, OFS_IRQ_STAT, 0);
        chk("frame_err", 4, q[3:0]);
        bus(0, 5'h14, 0);
        chk("unmapped", 0, q);
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        bus(0, OFS_CTRL, 0);
        chk("ctrl_reset", 3, q);
        bus(0, OFS_IRQ_MASK, 0);
        chk("mask_reset", 0, q);
        t_fast;
        t_width;
        t_pulser;
        trig(0, 1, 0);
        trig(1, 0, 1);
        t_gain;
        report_and_stop;
    end
    initial begin
        #300000;
        fail_count++;
        report_and_stop;
    end
endmodule
